// [rtl/qsas_consts.vh]
`ifndef QSAS_CONSTS_VH
`define QSAS_CONSTS_VH

// ==========================================================
// Pad states, ordered as the base-five digit value
`define QSAS_PAD_GND        3'h0
`define QSAS_PAD_RES_LOW    3'h1
`define QSAS_PAD_OPEN       3'h2
`define QSAS_PAD_RES_HIGH   3'h3
`define QSAS_PAD_SUPPLY     3'h4

// ==========================================================
// Address arithmetic
`define QSAS_ADDR_BASE      7'h01
`define QSAS_WEIGHT_HIGH    7'h19
`define QSAS_WEIGHT_MID     7'h05
`define QSAS_ADDR_COUNT     125

// ==========================================================
// Bus constants
`define QSAS_GEN_CALL_ADDR  8'h00
`define QSAS_SOFT_RST_BYTE  8'h06
`define QSAS_BITS_PER_BYTE  4'h8

// ==========================================================
// Timing
`define QSAS_CLK_MHZ        40
`define QSAS_SETTLE_NS      1000

`endif

// [rtl/qsas_sync.v]
`default_nettype none

// ==========================================================
// Three-stage input filter: output moves once stages two and three agree
module qsas_sync #(
  parameter          WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             i_clock,
  input  wire             i_rst_n,
  // Data
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      o_sync <= RST_VAL;
    end
    else
    begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      // Per bit, so activity on one line never holds back another
      o_sync <= (stage2 & stage3) | (o_sync & (stage2 | stage3));
    end
  end

endmodule

`default_nettype wire

// [rtl/qsas_top.v]
`include "qsas_consts.vh"
`default_nettype none

// Operation
// - Up to 125 addresses from three pads
// - Each pad classified into one of five
// - Seven-bit address derived only from pads
// - Pads sampled at power-up and resets
// - Sensing powered down once address is known
// - Address is one plus base-five pad value
// - Output enable input is active low
// - Reset pin low reinitialises, incl. address
// - Bus soft reset acts like power-on reset
module qsas_top #(
  parameter SETTLE_NS = `QSAS_SETTLE_NS
) (
  // Clock and power-on reset
  input  wire       i_clock,
  input  wire       i_rst_n,
  // Device pins
  input  wire       i_reset_pin_n,
  input  wire       i_oe_n,
  input  wire       i_scl,
  input  wire       i_sda,
  output wire       o_sda_out,
  output reg        o_sda_oe,
  // Pad front end
  input  wire [2:0] i_addr_pad_low,
  input  wire [2:0] i_addr_pad_mid,
  input  wire [2:0] i_addr_pad_high,
  output reg        o_pad_sense_en,
  // Status towards the driver core
  output reg  [6:0] o_slave_addr,
  output reg        o_addr_valid,
  output reg        o_addr_match,
  output reg        o_read_req,
  output reg        o_led_enable,
  output reg        o_dev_rst_n
);

  localparam integer SETTLE_CYC_RAW = (SETTLE_NS * `QSAS_CLK_MHZ + 999) / 1000;
  localparam integer SETTLE_CYC     = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
  localparam [11:0]  SETTLE_LAST    = SETTLE_CYC[11:0] - 12'h001;

  localparam [2:0] AS_SENSE = 3'h1;
  localparam [2:0] AS_LATCH = 3'h2;
  localparam [2:0] AS_DONE  = 3'h4;

  localparam [5:0] BS_IDLE   = 6'h01;
  localparam [5:0] BS_ADDR   = 6'h02;
  localparam [5:0] BS_ACK_A  = 6'h04;
  localparam [5:0] BS_DATA   = 6'h08;
  localparam [5:0] BS_ACK_D  = 6'h10;
  localparam [5:0] BS_IGNORE = 6'h20;

  // ==========================================================
  // Input filtering
  wire       pin_rst_n_s;
  wire       oe_n_s;
  wire       scl_s;
  wire       sda_s;
  wire [8:0] pads_s;

  qsas_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_rst (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async (i_reset_pin_n),
    .o_sync  (pin_rst_n_s)
  );

  qsas_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_sync_bus (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async ({i_oe_n, i_scl, i_sda}),
    .o_sync  ({oe_n_s, scl_s, sda_s})
  );

  qsas_sync #(.WIDTH(9), .RST_VAL(9'h000)) u_sync_pad (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async ({i_addr_pad_high, i_addr_pad_mid, i_addr_pad_low}),
    .o_sync  (pads_s)
  );

  // ==========================================================
  // Combined reset: power-on, reset pin or bus soft reset
  reg  soft_rst;
  wire core_rst = !i_rst_n || !pin_rst_n_s || soft_rst;

  // ==========================================================
  // Pad classification and address arithmetic
  function [6:0] qsas_digit;
    input [2:0] lvl;
    begin
      // Out-of-range front-end codes saturate to supply
      if (lvl > `QSAS_PAD_SUPPLY)
        qsas_digit = {4'h0, `QSAS_PAD_SUPPLY};
      else
        qsas_digit = {4'h0, lvl};
    end
  endfunction

  wire [6:0] dig_low  = qsas_digit(pads_s[2:0]);
  wire [6:0] dig_mid  = qsas_digit(pads_s[5:3]);
  wire [6:0] dig_high = qsas_digit(pads_s[8:6]);
  // Max 1 + 124 = 125, fits in 7 bits
  wire [13:0] prod_high = dig_high * `QSAS_WEIGHT_HIGH;
  wire [13:0] prod_mid  = dig_mid * `QSAS_WEIGHT_MID;
  wire [6:0]  next_addr = `QSAS_ADDR_BASE + prod_high[6:0]
                          + prod_mid[6:0] + dig_low;

  // ==========================================================
  // Sense sequence
  reg [2:0]  as_state;
  reg [11:0] settle_cnt;

  always @(posedge i_clock)
  begin
    if (core_rst)
    begin
      as_state       <= AS_SENSE;
      settle_cnt     <= 12'h000;
      o_pad_sense_en <= 1'b1;
      o_slave_addr   <= 7'h00;
      o_addr_valid   <= 1'b0;
    end
    else
    begin
      case (as_state)
        AS_SENSE:
        begin
          // Wait for the front end and the three-stage filter to settle
          if (settle_cnt == SETTLE_LAST)
            as_state <= AS_LATCH;
          else
            settle_cnt <= settle_cnt + 12'h001;
        end
        AS_LATCH:
        begin
          o_slave_addr   <= next_addr;
          o_addr_valid   <= 1'b1;
          o_pad_sense_en <= 1'b0;
          as_state       <= AS_DONE;
        end
        AS_DONE:
        begin
          // Pads stay unpowered until the next reset
          o_pad_sense_en <= 1'b0;
        end
        default:
          as_state <= AS_SENSE;
      endcase
    end
  end

  // ==========================================================
  // Output enable, forced off while in reset
  always @(posedge i_clock)
  begin
    if (core_rst)
    begin
      o_led_enable <= 1'b0;
      o_dev_rst_n  <= 1'b0;
    end
    else
    begin
      o_led_enable <= !oe_n_s;
      o_dev_rst_n  <= 1'b1;
    end
  end

  // ==========================================================
  // Bus address receiver
  reg       scl_d;
  reg       sda_d;
  reg [5:0] bs_state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg       gcall;
  reg       soft_armed;

  wire scl_rise   = scl_s && !scl_d;
  wire scl_fall   = !scl_s && scl_d;
  wire start_cond = scl_s && scl_d && sda_d && !sda_s;
  wire stop_cond  = scl_s && scl_d && !sda_d && sda_s;
  wire byte_done  = scl_fall && (bit_cnt == `QSAS_BITS_PER_BYTE);
  wire own_match  = o_addr_valid && (shreg[7:1] == o_slave_addr);

  assign o_sda_out = 1'b0;

  always @(posedge i_clock)
  begin
    if (core_rst)
    begin
      scl_d        <= 1'b1;
      sda_d        <= 1'b1;
      bs_state     <= BS_IDLE;
      bit_cnt      <= 4'h0;
      shreg        <= 8'h00;
      gcall        <= 1'b0;
      soft_armed   <= 1'b0;
      soft_rst     <= 1'b0;
      o_sda_oe     <= 1'b0;
      o_addr_match <= 1'b0;
      o_read_req   <= 1'b0;
    end
    else
    begin
      scl_d        <= scl_s;
      sda_d        <= sda_s;
      o_addr_match <= 1'b0;
      if (stop_cond)
      begin
        bs_state   <= BS_IDLE;
        o_sda_oe   <= 1'b0;
        soft_rst   <= soft_armed;
        soft_armed <= 1'b0;
      end
      else if (start_cond)
      begin
        // First byte after any START is taken as the address
        bs_state <= BS_ADDR;
        bit_cnt  <= 4'h0;
        o_sda_oe <= 1'b0;
      end
      else
      begin
        case (bs_state)
          BS_IDLE:
            o_sda_oe <= 1'b0;
          BS_ADDR, BS_DATA:
          begin
            if (scl_rise)
            begin
              shreg   <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (byte_done && bs_state == BS_ADDR)
            begin
              gcall <= (shreg == `QSAS_GEN_CALL_ADDR) && o_addr_valid;
              if (own_match)
              begin
                bs_state     <= BS_ACK_A;
                o_sda_oe     <= 1'b1;
                o_addr_match <= 1'b1;
                o_read_req   <= shreg[0];
              end
              else if ((shreg == `QSAS_GEN_CALL_ADDR) && o_addr_valid)
              begin
                bs_state <= BS_ACK_A;
                o_sda_oe <= 1'b1;
              end
              else
                bs_state <= BS_IGNORE;
            end
            else if (byte_done)
            begin
              if (shreg == `QSAS_SOFT_RST_BYTE)
              begin
                bs_state   <= BS_ACK_D;
                o_sda_oe   <= 1'b1;
                soft_armed <= 1'b1;
              end
              else
                bs_state <= BS_IGNORE;
            end
          end
          BS_ACK_A:
          begin
            if (scl_fall)
            begin
              o_sda_oe <= 1'b0;
              bit_cnt  <= 4'h0;
              // Later bytes of an own transfer belong to the register core
              bs_state <= gcall ? BS_DATA : BS_IGNORE;
            end
          end
          BS_ACK_D:
          begin
            if (scl_fall)
            begin
              o_sda_oe <= 1'b0;
              bs_state <= BS_IGNORE;
            end
          end
          BS_IGNORE:
            o_sda_oe <= 1'b0;
          default:
          begin
            bs_state <= BS_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
      // The soft reset pulse clears itself through core_rst next cycle
    end
  end

endmodule

`default_nettype wire

// [tb/qsas_bus_ctrl.sv]
`default_nettype none
// ==========
// Bus controller; both lines rest high between frames
module qsas_bus_ctrl (
  input  wire logic i_clock,
  input  wire logic i_sda,
  output var logic  o_scl,
  output var logic  o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic start;
    o_sda <= 1'b0;
    tick(8);
    o_scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop;
    o_sda <= 1'b0;
    tick(4);
    o_scl <= 1'b1;
    tick(8);
    o_sda <= 1'b1;
    tick(8);
  endtask
  // Data moves only mid-low so the filters never see it change with SCL high
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      o_sda <= b[i];
      tick(4);
      o_scl <= 1'b1;
      tick(8);
      o_scl <= 1'b0;
      tick(4);
    end
    o_sda <= 1'b1;
    tick(4);
    o_scl <= 1'b1;
    tick(4);
    ack = !i_sda;
    tick(4);
    o_scl <= 1'b0;
    tick(4);
  endtask
  task automatic frame(input logic [6:0] a, input logic rw, output logic ack);
    start;
    xfer({a, rw}, ack);
    stop;
  endtask
endmodule
`default_nettype wire

// [tb/qsas_sva.sv]
`default_nettype none
// ==========
// Latch, acknowledge and enable properties
module qsas_sva (
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic       i_reset_pin_n,
  input wire logic       i_oe_n,
  input wire logic       o_sda_oe,
  input wire logic       o_pad_sense_en,
  input wire logic [6:0] o_slave_addr,
  input wire logic       o_addr_valid,
  input wire logic       o_addr_match,
  input wire logic       o_led_enable,
  input wire logic       o_dev_rst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  AST_ADDR_RANGE: assert property (o_addr_valid |-> o_slave_addr inside {[7'h01:7'h7d]})
    else $error("address out of range");
  AST_SENSE_OFF: assert property (o_addr_valid |-> !o_pad_sense_en)
    else $error("sensing on after latch");
  AST_ADDR_HOLD: assert property ($past(o_addr_valid) && o_addr_valid |-> $stable(o_slave_addr))
    else $error("latched address moved");
  AST_MATCH_ACK: assert property (o_addr_match |-> o_sda_oe && o_addr_valid)
    else $error("match without ack");
  AST_MATCH_PULSE: assert property (o_addr_match |=> !o_addr_match)
    else $error("match longer than a cycle");
  AST_RESET_STATE: assert property (!o_dev_rst_n |-> o_pad_sense_en && !o_addr_valid && !o_led_enable)
    else $error("reset state wrong");
  AST_LED_ON: assert property ((!i_oe_n && o_dev_rst_n) [*7] |-> o_led_enable)
    else $error("leds not enabled");
  AST_LED_OFF: assert property (i_oe_n [*7] |-> !o_led_enable)
    else $error("leds enabled");
  AST_PIN_RESET: assert property (!i_reset_pin_n [*6] |-> !o_dev_rst_n && !o_addr_valid)
    else $error("pin reset ignored");
  AST_LATCH_TIME: assert property ($rose(o_dev_rst_n) |-> ##[1:60] o_addr_valid)
    else $error("address not latched in time");
  cover property (o_addr_match);
  cover property (o_addr_valid && o_led_enable);
  cover property ($fell(o_dev_rst_n) && i_reset_pin_n);
endmodule
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clock       = 1'b0;
  logic       i_rst_n       = 1'b0;
  logic       i_reset_pin_n = 1'b1;
  logic       i_oe_n        = 1'b1;
  logic [2:0] pad_h         = 3'h0;
  logic [2:0] pad_m         = 3'h0;
  logic [2:0] pad_l         = 3'h0;
  logic       ack;
  wire        scl, m_sda, sda_out, sda_oe, sense_en, valid, match, rd, led, dev_rst_n;
  wire  [6:0] addr;
  wire        sda_line = m_sda & (sda_oe ? sda_out : 1'b1);
  int         mismatches      = 0;
  int         samples_checked = 0;
  int         cycles          = 0;
  int         matches_seen    = 0;
  int         rst_low_cycles  = 0;
  always #12.5 i_clock = ~i_clock;
  // One-cycle pulses are counted here; the tasks look long after they end
  always @(posedge i_clock)
  begin
    if (match === 1'b1)
      matches_seen++;
    if (dev_rst_n === 1'b0)
      rst_low_cycles++;
  end
  qsas_top dut_u (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_reset_pin_n(i_reset_pin_n), .i_oe_n(i_oe_n),
    .i_scl(scl), .i_sda(sda_line), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_addr_pad_low(pad_l), .i_addr_pad_mid(pad_m), .i_addr_pad_high(pad_h),
    .o_pad_sense_en(sense_en), .o_slave_addr(addr), .o_addr_valid(valid),
    .o_addr_match(match), .o_read_req(rd), .o_led_enable(led), .o_dev_rst_n(dev_rst_n)
  );
  qsas_bus_ctrl bus_u (.i_clock(i_clock), .i_sda(sda_line), .o_scl(scl), .o_sda(m_sda));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic wait_valid;
    for (int i = 0; i < 100 && valid !== 1'b1; i++) tick(1);
  endtask
  task automatic set_pads(input logic [2:0] h, input logic [2:0] m, input logic [2:0] l);
    @(posedge i_clock);
    pad_h <= h;
    pad_m <= m;
    pad_l <= l;
  endtask
  task automatic power_reset;
    i_rst_n <= 1'b0;
    tick(5);
    i_rst_n <= 1'b1;
    tick(2);
    wait_valid;
  endtask
  task automatic t_addr_map;
    int h, m, l;
    for (int p = 0; p < 10; p++)
    begin
      h = p % 5;
      m = (p < 5) ? h : 4 - h;
      l = (p < 5) ? h : (h + 2) % 5;
      set_pads(3'(h), 3'(m), 3'(l));
      power_reset;
      check({1'b0, addr}, 8'(1 + 25 * h + 5 * m + l));
      check({7'h00, sense_en}, 8'h00);
    end
    // Front-end codes above supply count as supply
    set_pads(3'h7, 3'h5, 3'h6);
    power_reset;
    check({1'b0, addr}, 8'h7d);
    $display("t_addr_map done");
  endtask
  task automatic t_pin_reset;
    set_pads(3'h0, 3'h0, 3'h0);
    power_reset;
    set_pads(3'h4, 3'h4, 3'h4);
    tick(60);
    check({1'b0, addr}, 8'h01);
    i_reset_pin_n <= 1'b0;
    tick(8);
    check({7'h00, valid}, 8'h00);
    check({7'h00, dev_rst_n}, 8'h00);
    i_reset_pin_n <= 1'b1;
    tick(8);
    wait_valid;
    check({1'b0, addr}, 8'h7d);
    $display("t_pin_reset done");
  endtask
  task automatic t_soft_reset;
    int n0;
    n0 = rst_low_cycles;
    set_pads(3'h0, 3'h1, 3'h2);
    // Any other command after a general call is refused and resets nothing
    bus_u.start;
    bus_u.xfer(8'h00, ack);
    check({7'h00, ack}, 8'h01);
    bus_u.xfer(8'h07, ack);
    check({7'h00, ack}, 8'h00);
    bus_u.stop;
    tick(2);
    check({1'b0, addr}, 8'h7d);
    check({7'h00, valid}, 8'h01);
    bus_u.start;
    bus_u.xfer(8'h00, ack);
    check({7'h00, ack}, 8'h01);
    bus_u.xfer(8'h06, ack);
    check({7'h00, ack}, 8'h01);
    bus_u.stop;
    tick(2);
    wait_valid;
    check({1'b0, addr}, 8'h08);
    check(8'(rst_low_cycles - n0), 8'h01);
    $display("t_soft_reset done");
  endtask
  task automatic t_match;
    int n0;
    n0 = matches_seen;
    bus_u.frame(7'h08, 1'b1, ack);
    check({7'h00, ack}, 8'h01);
    check({7'h00, rd}, 8'h01);
    check(8'(matches_seen - n0), 8'h01);
    bus_u.frame(7'h09, 1'b0, ack);
    check({7'h00, ack}, 8'h00);
    check(8'(matches_seen - n0), 8'h01);
    bus_u.frame(7'h08, 1'b0, ack);
    check({7'h00, rd}, 8'h00);
    check(8'(matches_seen - n0), 8'h02);
    $display("t_match done");
  endtask
  task automatic t_oe;
    i_oe_n <= 1'b0;
    tick(8);
    check({7'h00, led}, 8'h01);
    i_oe_n <= 1'b1;
    tick(8);
    check({7'h00, led}, 8'h00);
    $display("t_oe done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // A hang anywhere ends the run as a failure
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      report_and_stop;
    end
  end
  initial
  begin
    tick(5);
    i_rst_n <= 1'b1;
    tick(2);
    wait_valid;
    check({1'b0, addr}, 8'h01);
    t_addr_map;
    t_pin_reset;
    t_soft_reset;
    t_match;
    t_oe;
    report_and_stop;
  end
endmodule
bind qsas_top qsas_sva chk_u (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_reset_pin_n(i_reset_pin_n), .i_oe_n(i_oe_n),
  .o_sda_oe(o_sda_oe), .o_pad_sense_en(o_pad_sense_en), .o_slave_addr(o_slave_addr),
  .o_addr_valid(o_addr_valid), .o_addr_match(o_addr_match), .o_led_enable(o_led_enable),
  .o_dev_rst_n(o_dev_rst_n)
);
`default_nettype wire
